/* File: dv/crs_dec_model.sv */
// crs_dec_model: decoder and alu side model, one command per core enable cycle
// assumes the register set raises o_cpu_en every second clock after reset
`timescale 1ns/1ps
module crs_dec_model import crs_pkg::*; (
	// clock and enable
	input  wire logic i_core_clk,
	input  wire logic i_cpu_en,
	// command
	output crs_cmd_t  o_cmd
);
	initial begin
		o_cmd = '0;
	end

	// enable seen low at an edge means the next edge takes the command
	task automatic send(input crs_cmd_t c);
		@(posedge i_core_clk);
		while (i_cpu_en !== 1'b0) begin
			@(posedge i_core_clk);
		end
		o_cmd <= c;
		@(posedge i_core_clk);
		o_cmd <= '0;
	endtask : send
endmodule : crs_dec_model

/* File: dv/test_cpu_register_set_and_status_flags.sv */
// test_cpu_register_set_and_status_flags: self-checking bench of the cpu register set
// assumes crs_dec_model as the decoder side; software port driven by the bench
`timescale 1ns/1ps
module test_cpu_register_set_and_status_flags import crs_pkg::*;;
	logic        core_clk;
	logic        rst;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        we;
	logic        re;
	logic [15:0] rdata;
	crs_cmd_t    cmd;
	logic        cpu_en;
	crs_flags_t  flags;
	logic [23:0] data_addr;
	logic        dp_fast;
	logic        irq_take;
	int          n_errors;
	int          comparisons;
	crs_cmd_t    c;
	logic [15:0] d;

	crs_regs i_dut (.i_core_clk(core_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_we(we), .i_re(re), .o_rdata(rdata), .i_cmd(cmd), .o_cpu_en(cpu_en),
		.o_flags(flags), .o_data_addr(data_addr), .o_dp_fast(dp_fast), .o_irq_take(irq_take));
	crs_dec_model i_dec (.i_core_clk(core_clk), .i_cpu_en(cpu_en), .o_cmd(cmd));

	always #12.5 core_clk = ~core_clk;

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk);
		we <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge core_clk);
		we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk);
		re <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		re <= 1'b0;
		#1;
		check($sformatf("register %0d", a), {8'h00, rdata}, {8'h00, e});
	endtask : rd

	function automatic crs_cmd_t mk(input crs_op_t o, input logic [3:0] r, input logic [15:0] v);
		mk = '0;
		mk.op = o;
		mk.dst = r;
		mk.use_sacc = (r == RIX_SACC);
		mk.operand = v;
	endfunction : mk

	task automatic run(input crs_cmd_t k);
		i_dec.send(k);
		#1;
		check("core enable after command", {23'h000000, cpu_en}, 24'h000000);
	endtask : run

	// one command, then the status word it leaves behind
	task automatic op(input crs_op_t o, input logic [3:0] r, input logic [15:0] v,
		input logic [10:0] f);
		run(mk(o, r, v));
		check("flags", {13'h0000, flags}, {13'h0000, f});
	endtask : op

	task automatic irq(input logic [2:0] p, input logic n, input logic t, input logic [10:0] f);
		crs_cmd_t k;
		k = mk(OPC_TAKE_IRQ, RIX_PACC, 16'h0000);
		k.prio = p;
		k.nmi = n;
		run(k);
		check("irq take", {23'h000000, irq_take}, {23'h000000, t});
		check("flags", {13'h0000, flags}, {13'h0000, f});
		@(posedge core_clk);
		#1;
		check("irq pulse end", {23'h000000, irq_take}, 24'h000000);
	endtask : irq

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	// generous bound: the sequence needs well under a thousand clocks
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		tally_and_finish();
	end

	crs_op_t     fop[9] = '{OPC_SET_FLAGS, OPC_CLR_OVF, OPC_CLR_IRQ_MSK, OPC_SET_IRQ_MSK,
		OPC_CLR_CARRY, OPC_CLR_WIDTH, OPC_SET_WIDTH, OPC_SET_CARRY, OPC_CLR_FLAGS};
	logic [10:0] fexp[9] = '{11'h0FF, 11'h0BF, 11'h0BB, 11'h0BF, 11'h0BE, 11'h09E, 11'h0BE,
		11'h0BF, 11'h000};
	crs_amode_t  am[9] = '{AM_ABS, AM_ABS_IX1, AM_ABS_IX2, AM_DIR, AM_DIR_IX1, AM_STK,
		AM_BLK_SRC, AM_BLK_DST, AM_DIR};
	logic [15:0] abase[9] = '{16'h1234, 16'h1234, 16'h1234, 16'h0090, 16'h0010, 16'h0005,
		16'h0000, 16'h0000, 16'h0034};
	logic [23:0] aexp[9] = '{24'h7E1234, 24'h7E1244, 24'h7E1254, 24'h010010, 24'h00FFA0,
		24'h000105, 24'h3C0010, 24'h3C0020, 24'h001234};

	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		we = 1'b0;
		re = 1'b0;
		n_errors = 0;
		comparisons = 0;
		repeat (4) @(posedge core_clk);
		check("flags in reset", {13'h0000, flags}, 24'h000004);
		rst <= 1'b0;
		for (int i = 0; i < 11; i++) begin
			rd(4'(i), (i == 9) ? 16'h0004 : 16'h0000);
		end
		@(posedge core_clk);
		#1;
		check("read data after one cycle", {8'h00, rdata}, 24'h000000);
		for (int i = 0; i < 11; i++) begin
			d = 16'hF0F0 ^ 16'(i);
			wr(4'(i), d);
			rd(4'(i), (i > 9) ? 16'h0000 : (i == 6 || i == 7) ? (d & 16'h00FF) :
				(i == 9) ? (d & 16'h07FF) : d);
		end
		wr(RIX_FLAGS, 16'h0000);
		$display("test registers done");
		for (int i = 0; i < 9; i++) begin
			op(fop[i], RIX_PACC, 16'h00FF, fexp[i]);
		end
		$display("test flag ops done");
		wr(RIX_PACC, 16'h7FFF);
		op(OPC_ADD_CARRY, RIX_PACC, 16'h0001, 11'h0C0);
		rd(RIX_PACC, 16'h8000);
		wr(RIX_SACC, 16'hFFFF);
		op(OPC_ADD_CARRY, RIX_SACC, 16'h0001, 11'h003);
		rd(RIX_SACC, 16'h0000);
		op(OPC_SUB_BORROW, RIX_PACC, 16'h0001, 11'h041);
		rd(RIX_PACC, 16'h7FFF);
		op(OPC_SET_WIDTH, RIX_PACC, 16'h0000, 11'h061);
		wr(RIX_PACC, 16'h127F);
		op(OPC_ADD_CARRY, RIX_PACC, 16'h0001, 11'h0E0);
		rd(RIX_PACC, 16'h1281);
		op(OPC_SET_FLAGS, RIX_PACC, 16'h0008, 11'h0E8);
		op(OPC_CLR_FLAGS, RIX_PACC, 16'h00C0, 11'h028);
		wr(RIX_PACC, 16'h3399);
		op(OPC_ADD_CARRY, RIX_PACC, 16'h0001, 11'h02B);
		rd(RIX_PACC, 16'h3300);
		op(OPC_CLR_WIDTH, RIX_PACC, 16'h0000, 11'h00B);
		op(OPC_ADD_CARRY, RIX_PACC, 16'h0699, 11'h008);
		rd(RIX_PACC, 16'h4000);
		op(OPC_CLR_FLAGS, RIX_PACC, 16'h0008, 11'h000);
		wr(RIX_PACC, 16'h8001);
		op(OPC_SHIFT_L, RIX_PACC, 16'h0000, 11'h001);
		c = mk(OPC_SHIFT_R, RIX_PACC, 16'h0000);
		c.rot = 1'b1;
		run(c);
		check("flags", {13'h0000, flags}, 24'h000080);
		rd(RIX_PACC, 16'h8001);
		$display("test arithmetic done");
		op(OPC_SET_FLAGS, RIX_PACC, 16'h0010, 11'h090);
		wr(RIX_XIDX, 16'h1234);
		op(OPC_LOAD, RIX_XIDX, 16'h00FF, 11'h090);
		rd(RIX_XIDX, 16'h12FF);
		op(OPC_SET_WIDTH, RIX_PACC, 16'h0000, 11'h0B0);
		op(OPC_LOAD, RIX_PACC, 16'hAB00, 11'h032);
		rd(RIX_PACC, 16'h8000);
		op(OPC_CLR_FLAGS, RIX_PACC, 16'h00B2, 11'h000);
		wr(RIX_PCNT, 16'hFFFF);
		wr(RIX_PBANK, 16'h0005);
		op(OPC_PC_INC, RIX_PACC, 16'h0000, 11'h000);
		rd(RIX_PCNT, 16'h0000);
		rd(RIX_PBANK, 16'h0006);
		wr(RIX_PCNT, 16'hFFF0);
		c = mk(OPC_BRANCH, RIX_PACC, 16'h0020);
		run(c);
		rd(RIX_PCNT, 16'h0010);
		rd(RIX_PBANK, 16'h0007);
		c.operand = 16'hFFE0;
		run(c);
		rd(RIX_PBANK, 16'h0006);
		c.cond_val = 1'b1;
		run(c);
		rd(RIX_PCNT, 16'hFFF0);
		$display("test program counter done");
		wr(RIX_XIDX, 16'h0010);
		wr(RIX_YIDX, 16'h0020);
		wr(RIX_DBANK, 16'h007E);
		wr(RIX_DPAGE, 16'hFF80);
		wr(RIX_SPTR, 16'h0100);
		for (int i = 0; i < 9; i++) begin
			if (i == 8) begin
				wr(RIX_DPAGE, 16'h1200);
			end
			c = mk(OPC_NONE, RIX_PACC, 16'h0000);
			c.amode = am[i];
			c.base = abase[i];
			c.bank = 8'h3C;
			run(c);
			check("address", data_addr, aexp[i]);
			check("fast page", {23'h000000, dp_fast}, (i == 8) ? 24'h000001 : 24'h000000);
		end
		$display("test addressing done");
		irq(3'h3, 1'b0, 1'b1, 11'h304);
		op(OPC_CLR_IRQ_MSK, RIX_PACC, 16'h0000, 11'h300);
		irq(3'h3, 1'b0, 1'b0, 11'h300);
		irq(3'h4, 1'b0, 1'b1, 11'h404);
		irq(3'h7, 1'b0, 1'b0, 11'h404);
		irq(3'h0, 1'b1, 1'b1, 11'h404);
		$display("test interrupts done");
		tally_and_finish();
	end
endmodule : test_cpu_register_set_and_status_flags

/* File: logic/crs_addr.sv */
// crs_addr: 24-bit data address former for the addressing families
// assumes register values come straight from the register set flip-flops
`timescale 1ns/1ps
module crs_addr import crs_pkg::*; (
	// request
	input  wire crs_amode_t  i_amode,
	input  wire logic [15:0] i_base,
	input  wire logic [7:0]  i_bank,
	// register values
	input  wire logic [15:0] i_xidx,
	input  wire logic [15:0] i_yidx,
	input  wire logic [15:0] i_sptr,
	input  wire logic [15:0] i_dpage,
	input  wire logic [7:0]  i_dbank,
	input  wire logic        i_idx8,
	// result
	output logic      [23:0] o_addr,
	output logic             o_dp_fast
);

	logic [23:0] ix1;
	logic [23:0] ix2;
	logic [23:0] dabs;
	logic [23:0] dpg;
	logic [15:0] stk;

	assign ix1  = {8'h00, crs_merge(16'h0000, i_xidx, i_idx8)};
	assign ix2  = {8'h00, crs_merge(16'h0000, i_yidx, i_idx8)};
	assign dabs = {i_dbank, i_base};
	// full 24-bit add lets a high direct page spill into bank 1
	assign dpg  = {8'h00, i_dpage} + {16'h0000, i_base[7:0]};
	assign stk  = i_sptr + i_base;
	assign o_dp_fast = (i_dpage[7:0] == 8'h00);

	always_comb begin
		case (i_amode)
			AM_ABS:     o_addr = dabs;
			AM_ABS_IX1: o_addr = dabs + ix1;
			AM_ABS_IX2: o_addr = dabs + ix2;
			AM_DIR:     o_addr = dpg;
			AM_DIR_IX1: o_addr = dpg + ix1;
			AM_STK:     o_addr = {8'h00, stk};
			AM_BLK_SRC: o_addr = {i_bank, i_xidx};
			AM_BLK_DST: o_addr = {i_bank, i_yidx};
			default:    o_addr = dabs;
		endcase
	end

endmodule : crs_addr

/* File: logic/crs_addsub.sv */
// crs_addsub: binary or decimal add and subtract with result flags
// assumes carry in means no borrow for subtraction; purely combinational
`timescale 1ns/1ps
module crs_addsub import crs_pkg::*; (
	// operands
	input  wire logic [15:0] i_lhs,
	input  wire logic [15:0] i_rhs,
	input  wire logic        i_cin,
	// mode
	input  wire logic        i_sub,
	input  wire logic        i_dec,
	input  wire logic        i_w8,
	// result
	output crs_alu_t         o_res
);

	always_comb begin
		logic [15:0] rop;
		logic [16:0] sum16;
		logic [8:0]  sum8;
		logic [15:0] dres;
		logic [4:0]  dg;
		logic        cy;
		logic        c8;
		logic [15:0] r;
		rop   = i_sub ? ~i_rhs : i_rhs;
		sum16 = {1'b0, i_lhs} + {1'b0, rop} + {16'h0000, i_cin};
		sum8  = {1'b0, i_lhs[7:0]} + {1'b0, rop[7:0]} + {8'h00, i_cin};
		dres  = 16'h0000;
		cy    = i_cin;
		c8    = 1'b0;
		dg    = 5'h00;
		r     = 16'h0000;
		// digit chain runs over all four digits; the upper two are dropped in 8-bit mode
		for (int k = 0; k < BCD_DIGITS; k++) begin
			if (i_sub) begin
				dg = {1'b0, i_lhs[k*4 +: 4]} - {1'b0, i_rhs[k*4 +: 4]} - {4'h0, ~cy};
				cy = ~dg[4];
				if (dg[4])
					dg = dg + BCD_TEN;
			end else begin
				dg = {1'b0, i_lhs[k*4 +: 4]} + {1'b0, i_rhs[k*4 +: 4]} + {4'h0, cy};
				cy = (dg > BCD_MAX);
				if (cy)
					dg = dg + BCD_ADJ;
			end
			dres[k*4 +: 4] = dg[3:0];
			if (k == 1)
				c8 = cy;
		end
		r = i_dec ? dres : sum16[15:0];
		o_res.res   = r;
		o_res.carry = i_dec ? (i_w8 ? c8 : cy) : (i_w8 ? sum8[8] : sum16[16]);
		// signed range exceeded when like-signed operands give an unlike sign
		o_res.ovf   = i_w8 ? ((i_lhs[7] == rop[7]) && (sum16[7] != i_lhs[7]))
			: ((i_lhs[15] == rop[15]) && (sum16[15] != i_lhs[15]));
		{o_res.zero, o_res.neg} = crs_zn(r, i_w8);
	end

endmodule : crs_addsub

/* File: logic/crs_pkg.sv */
// crs_pkg: constants, types and shared helpers of the cpu register set
// assumes a single core clock; decoder commands arrive as one packed struct
package crs_pkg;

	localparam int          DATA_W      = 16;
	localparam int          BCD_DIGITS  = 4;

	// register indices on the software port and for decoder loads
	localparam logic [3:0]  RIX_PACC    = 4'h0;
	localparam logic [3:0]  RIX_SACC    = 4'h1;
	localparam logic [3:0]  RIX_XIDX    = 4'h2;
	localparam logic [3:0]  RIX_YIDX    = 4'h3;
	localparam logic [3:0]  RIX_SPTR    = 4'h4;
	localparam logic [3:0]  RIX_PCNT    = 4'h5;
	localparam logic [3:0]  RIX_PBANK   = 4'h6;
	localparam logic [3:0]  RIX_DBANK   = 4'h7;
	localparam logic [3:0]  RIX_DPAGE   = 4'h8;
	localparam logic [3:0]  RIX_FLAGS   = 4'h9;

	// values after reset
	localparam logic [15:0] WORD_RST    = 16'h0000;
	localparam logic [7:0]  BANK_RST    = 8'h00;
	localparam logic [10:0] FLAGS_RST   = 11'h004;

	// direct page base from which the window reaches into bank 1
	localparam logic [15:0] DPAGE_SPAN  = 16'hFF01;

	// decimal digit correction
	localparam logic [4:0]  BCD_MAX     = 5'h09;
	localparam logic [4:0]  BCD_ADJ     = 5'h06;
	localparam logic [4:0]  BCD_TEN     = 5'h0A;

	typedef enum logic [4:0] {
		OPC_NONE        = 5'b00000,
		OPC_ADD_CARRY   = 5'b00001,
		OPC_SUB_BORROW  = 5'b00010,
		OPC_LOAD        = 5'b00011,
		OPC_SHIFT_L     = 5'b00100,
		OPC_SHIFT_R     = 5'b00101,
		OPC_SET_FLAGS   = 5'b00110,
		OPC_CLR_FLAGS   = 5'b00111,
		OPC_SET_CARRY   = 5'b01000,
		OPC_CLR_CARRY   = 5'b01001,
		OPC_SET_IRQ_MSK = 5'b01010,
		OPC_CLR_IRQ_MSK = 5'b01011,
		OPC_SET_WIDTH   = 5'b01100,
		OPC_CLR_WIDTH   = 5'b01101,
		OPC_CLR_OVF     = 5'b01110,
		OPC_PC_INC      = 5'b01111,
		OPC_BRANCH      = 5'b10000,
		OPC_TAKE_IRQ    = 5'b10001
	} crs_op_t;

	typedef enum logic [2:0] {
		AM_ABS      = 3'b000,
		AM_ABS_IX1  = 3'b001,
		AM_ABS_IX2  = 3'b010,
		AM_DIR      = 3'b011,
		AM_DIR_IX1  = 3'b100,
		AM_STK      = 3'b101,
		AM_BLK_SRC  = 3'b110,
		AM_BLK_DST  = 3'b111
	} crs_amode_t;

	typedef struct packed {
		logic [2:0] cpu_priority_level;
		logic       neg;
		logic       ovf;
		logic       dat8;
		logic       idx8;
		logic       dec;
		logic       irq_mask;
		logic       zero;
		logic       carry;
	} crs_flags_t;

	typedef struct packed {
		crs_op_t    op;
		logic [3:0] dst;
		logic       use_sacc;
		logic       rot;
		logic [1:0] cond_sel;
		logic       cond_val;
		logic [15:0] operand;
		crs_amode_t amode;
		logic [15:0] base;
		logic [7:0] bank;
		logic [2:0] prio;
		logic       nmi;
	} crs_cmd_t;

	typedef struct packed {
		logic [15:0] res;
		logic       carry;
		logic       ovf;
		logic       zero;
		logic       neg;
	} crs_alu_t;

	typedef struct packed {
		logic [15:0] pacc;
		logic [15:0] sacc;
		logic [15:0] xidx;
		logic [15:0] yidx;
		logic [15:0] sptr;
		logic [15:0] pcnt;
		logic [15:0] dpage;
		logic [7:0] pbank;
		logic [7:0] dbank;
		crs_flags_t flags;
		logic [15:0] rdata;
		logic [23:0] addr;
		logic       dp_fast;
		logic       irq_take;
		logic       div;
	} crs_state_t;

	function automatic logic [15:0] crs_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic w8);
		return w8 ? {old_v[15:8], new_v[7:0]} : new_v;
	endfunction : crs_merge

	// {zero, negative} of a value at the selected width
	function automatic logic [1:0] crs_zn(input logic [15:0] v, input logic w8);
		return w8 ? {(v[7:0] == 8'h00), v[7]} : {(v == 16'h0000), v[15]};
	endfunction : crs_zn

endpackage : crs_pkg

/* File: logic/crs_regs.sv */
// crs_regs: programmer-visible register set and status flags of the cpu core
// assumes the decoder holds i_cmd for the cycle in which o_cpu_en is high
// and that software strobes are single cycles, never both at once
`timescale 1ns/1ps
module crs_regs import crs_pkg::*; #(
	parameter int DATA_WIDTH = DATA_W
) (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// software register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_we,
	input  wire logic        i_re,
	output logic      [15:0] o_rdata,
	// decoder and alu side
	input  wire crs_cmd_t    i_cmd,
	output logic             o_cpu_en,
	output crs_flags_t       o_flags,
	output logic      [23:0] o_data_addr,
	output logic             o_dp_fast,
	output logic             o_irq_take
);

	if (DATA_WIDTH != 16) begin : g_width_check
		$error("crs_regs serves a 16-bit data path only");
	end

	crs_state_t  st_reg;
	crs_state_t  st_next;
	crs_alu_t    alu;
	logic [15:0] acc_cur;
	logic [23:0] addr_w;
	logic        dp_fast_w;
	logic        cpu_en;

	// the core runs at half the input clock; one enable cycle in two
	assign cpu_en = st_reg.div;
	assign acc_cur = i_cmd.use_sacc ? st_reg.sacc : st_reg.pacc;

	crs_addsub u_addsub (
		.i_lhs (acc_cur),
		.i_rhs (i_cmd.operand),
		.i_cin (st_reg.flags.carry),
		.i_sub (i_cmd.op == OPC_SUB_BORROW),
		.i_dec (st_reg.flags.dec),
		.i_w8  (st_reg.flags.dat8),
		.o_res (alu)
	);

	crs_addr u_addr (
		.i_amode   (i_cmd.amode),
		.i_base    (i_cmd.base),
		.i_bank    (i_cmd.bank),
		.i_xidx    (st_reg.xidx),
		.i_yidx    (st_reg.yidx),
		.i_sptr    (st_reg.sptr),
		.i_dpage   (st_reg.dpage),
		.i_dbank   (st_reg.dbank),
		.i_idx8    (st_reg.flags.idx8),
		.o_addr    (addr_w),
		.o_dp_fast (dp_fast_w)
	);

	function automatic logic [15:0] rd_mux(input crs_state_t s, input logic [3:0] ix);
		case (ix)
			RIX_PACC:  return s.pacc;
			RIX_SACC:  return s.sacc;
			RIX_XIDX:  return s.xidx;
			RIX_YIDX:  return s.yidx;
			RIX_SPTR:  return s.sptr;
			RIX_PCNT:  return s.pcnt;
			RIX_PBANK: return {8'h00, s.pbank};
			RIX_DBANK: return {8'h00, s.dbank};
			RIX_DPAGE: return s.dpage;
			RIX_FLAGS: return {5'h00, s.flags};
			default:   return 16'h0000;
		endcase
	endfunction : rd_mux

	always_comb begin
		logic        w8;
		logic [15:0] sh;
		logic [15:0] ld;
		logic        cond_flag;
		logic [23:0] pcw;
		w8        = st_reg.flags.dat8;
		sh        = acc_cur;
		ld        = i_cmd.operand;
		cond_flag = 1'b0;
		pcw       = {st_reg.pbank, st_reg.pcnt};
		st_next          = st_reg;
		st_next.div      = ~st_reg.div;
		st_next.irq_take = 1'b0;
		st_next.rdata    = 16'h0000;
		if (cpu_en) begin
			st_next.addr    = addr_w;
			st_next.dp_fast = dp_fast_w;
			case (i_cmd.op)
				OPC_ADD_CARRY, OPC_SUB_BORROW: begin
					if (i_cmd.use_sacc)
						st_next.sacc = crs_merge(st_reg.sacc, alu.res, w8);
					else
						st_next.pacc = crs_merge(st_reg.pacc, alu.res, w8);
					st_next.flags.carry = alu.carry;
					st_next.flags.ovf   = alu.ovf;
					st_next.flags.zero  = alu.zero;
					st_next.flags.neg   = alu.neg;
				end
				OPC_LOAD: begin
					case (i_cmd.dst)
						RIX_PACC: begin
							st_next.pacc = crs_merge(st_reg.pacc, ld, w8);
							{st_next.flags.zero, st_next.flags.neg} = crs_zn(ld, w8);
						end
						RIX_SACC: begin
							st_next.sacc = crs_merge(st_reg.sacc, ld, w8);
							{st_next.flags.zero, st_next.flags.neg} = crs_zn(ld, w8);
						end
						RIX_XIDX: begin
							st_next.xidx = crs_merge(st_reg.xidx, ld, st_reg.flags.idx8);
							{st_next.flags.zero, st_next.flags.neg} =
								crs_zn(ld, st_reg.flags.idx8);
						end
						RIX_YIDX: begin
							st_next.yidx = crs_merge(st_reg.yidx, ld, st_reg.flags.idx8);
							{st_next.flags.zero, st_next.flags.neg} =
								crs_zn(ld, st_reg.flags.idx8);
						end
						RIX_SPTR:  st_next.sptr  = ld;
						RIX_DBANK: st_next.dbank = ld[7:0];
						RIX_DPAGE: st_next.dpage = ld;
						default: ;
					endcase
				end
				OPC_SHIFT_L: begin
					st_next.flags.carry = w8 ? sh[7] : sh[15];
					sh = {sh[14:0], i_cmd.rot & st_reg.flags.carry};
					if (i_cmd.use_sacc)
						st_next.sacc = crs_merge(st_reg.sacc, sh, w8);
					else
						st_next.pacc = crs_merge(st_reg.pacc, sh, w8);
					{st_next.flags.zero, st_next.flags.neg} = crs_zn(sh, w8);
				end
				OPC_SHIFT_R: begin
					st_next.flags.carry = sh[0];
					sh = {1'b0, sh[15:1]};
					if (w8)
						sh[7] = i_cmd.rot & st_reg.flags.carry;
					else
						sh[15] = i_cmd.rot & st_reg.flags.carry;
					if (i_cmd.use_sacc)
						st_next.sacc = crs_merge(st_reg.sacc, sh, w8);
					else
						st_next.pacc = crs_merge(st_reg.pacc, sh, w8);
					{st_next.flags.zero, st_next.flags.neg} = crs_zn(sh, w8);
				end
				// generic flag ops reach the eight low flag bits, not the level
				OPC_SET_FLAGS: st_next.flags[7:0] = st_reg.flags[7:0] | i_cmd.operand[7:0];
				OPC_CLR_FLAGS: st_next.flags[7:0] = st_reg.flags[7:0] & ~i_cmd.operand[7:0];
				OPC_SET_CARRY: st_next.flags.carry = 1'b1;
				OPC_CLR_CARRY: st_next.flags.carry = 1'b0;
				OPC_SET_IRQ_MSK: st_next.flags.irq_mask = 1'b1;
				OPC_CLR_IRQ_MSK: st_next.flags.irq_mask = 1'b0;
				OPC_SET_WIDTH: st_next.flags.dat8 = 1'b1;
				OPC_CLR_WIDTH: st_next.flags.dat8 = 1'b0;
				OPC_CLR_OVF:   st_next.flags.ovf = 1'b0;
				OPC_PC_INC: begin
					pcw = pcw + 24'h000001;
					{st_next.pbank, st_next.pcnt} = pcw;
				end
				OPC_BRANCH: begin
					case (i_cmd.cond_sel)
						2'b00:   cond_flag = st_reg.flags.carry;
						2'b01:   cond_flag = st_reg.flags.zero;
						2'b10:   cond_flag = st_reg.flags.ovf;
						default: cond_flag = st_reg.flags.neg;
					endcase
					// sign-extended offset so a carry or borrow walks the bank
					if (cond_flag == i_cmd.cond_val) begin
						pcw = pcw + {{8{i_cmd.operand[15]}}, i_cmd.operand};
						{st_next.pbank, st_next.pcnt} = pcw;
					end
				end
				OPC_TAKE_IRQ: begin
					if (i_cmd.nmi || (!st_reg.flags.irq_mask &&
						(i_cmd.prio > st_reg.flags.cpu_priority_level))) begin
						st_next.irq_take = 1'b1;
						st_next.flags.irq_mask = 1'b1;
						if (!i_cmd.nmi)
							st_next.flags.cpu_priority_level = i_cmd.prio;
					end
				end
				default: ;
			endcase
		end
		// software write lands after the core update, so it wins a same-cycle clash
		if (i_we) begin
			case (i_addr)
				RIX_PACC:  st_next.pacc  = i_wdata;
				RIX_SACC:  st_next.sacc  = i_wdata;
				RIX_XIDX:  st_next.xidx  = i_wdata;
				RIX_YIDX:  st_next.yidx  = i_wdata;
				RIX_SPTR:  st_next.sptr  = i_wdata;
				RIX_PCNT:  st_next.pcnt  = i_wdata;
				RIX_PBANK: st_next.pbank = i_wdata[7:0];
				RIX_DBANK: st_next.dbank = i_wdata[7:0];
				RIX_DPAGE: st_next.dpage = i_wdata;
				RIX_FLAGS: st_next.flags = i_wdata[10:0];
				default: ;
			endcase
		end
		if (i_re)
			st_next.rdata = rd_mux(st_reg, i_addr);
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '{pacc: WORD_RST, sacc: WORD_RST, xidx: WORD_RST, yidx: WORD_RST,
				sptr: WORD_RST, pcnt: WORD_RST, dpage: WORD_RST, pbank: BANK_RST,
				dbank: BANK_RST, flags: FLAGS_RST, rdata: WORD_RST, addr: 24'h000000,
				dp_fast: 1'b1, irq_take: 1'b0, div: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rdata     = st_reg.rdata;
	assign o_cpu_en    = cpu_en;
	assign o_flags     = st_reg.flags;
	assign o_data_addr = st_reg.addr;
	assign o_dp_fast   = st_reg.dp_fast;
	assign o_irq_take  = st_reg.irq_take;

	// checks

	property p_w8_keeps_high;
		@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && !i_we && i_cmd.op == OPC_ADD_CARRY && !i_cmd.use_sacc && st_reg.flags.dat8
		|=> st_reg.pacc[15:8] == $past(st_reg.pacc[15:8]);
	endproperty
	a_w8_keeps_high: assert property (p_w8_keeps_high) else $error("8-bit add touched high byte");

	property p_pc_bank_carry;
		@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && !i_we && i_cmd.op == OPC_PC_INC && st_reg.pcnt == 16'hFFFF
		|=> st_reg.pcnt == 16'h0000 && st_reg.pbank == $past(st_reg.pbank) + 8'h01;
	endproperty
	a_pc_bank_carry: assert property (p_pc_bank_carry) else $error("bank not carried");

	property p_masked_irq;
		@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && i_cmd.op == OPC_TAKE_IRQ && !i_cmd.nmi && st_reg.flags.irq_mask
		|=> !o_irq_take;
	endproperty
	a_masked_irq: assert property (p_masked_irq) else $error("masked interrupt taken");

	property p_take_sets_mask;
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_irq_take) |-> o_flags.irq_mask ##1 !o_irq_take;
	endproperty
	a_take_sets_mask: assert property (p_take_sets_mask) else $error("mask not set");

	property p_level_gate;
		@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && i_cmd.op == OPC_TAKE_IRQ && !i_cmd.nmi
		&& i_cmd.prio <= st_reg.flags.cpu_priority_level |=> !o_irq_take;
	endproperty
	a_level_gate: assert property (p_level_gate) else $error("low priority accepted");

	property p_neg_bit7;
		@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && !i_we && i_cmd.op == OPC_LOAD && i_cmd.dst == RIX_PACC && st_reg.flags.dat8
		|=> o_flags.neg == $past(i_cmd.operand[7])
		&& o_flags.zero == ($past(i_cmd.operand[7:0]) == 8'h00);
	endproperty
	a_neg_bit7: assert property (p_neg_bit7) else $error("8-bit zero/negative wrong");

	property p_clr_ovf;
		@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && !i_we && i_cmd.op == OPC_CLR_OVF |=> !o_flags.ovf [*2];
	endproperty
	a_clr_ovf: assert property (p_clr_ovf) else $error("overflow not cleared");

	property p_block_src;
		@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && !i_we && i_cmd.amode == AM_BLK_SRC
		|=> o_data_addr == {$past(i_cmd.bank), $past(st_reg.xidx)} ##1 $stable(o_data_addr);
	endproperty
	a_block_src: assert property (p_block_src) else $error("block source address wrong");

	property p_dp_fast;
		@(posedge i_core_clk) disable iff (i_rst)
		cpu_en |=> o_dp_fast == ($past(st_reg.dpage[7:0]) == 8'h00);
	endproperty
	a_dp_fast: assert property (p_dp_fast) else $error("fast page flag wrong");

	c_dp_span: cover property (@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && i_cmd.amode == AM_DIR && st_reg.dpage >= DPAGE_SPAN);
	c_irq_take: cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_irq_take));
	c_bcd_add: cover property (@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && i_cmd.op == OPC_ADD_CARRY && st_reg.flags.dec);
	c_branch_back: cover property (@(posedge i_core_clk) disable iff (i_rst)
		cpu_en && i_cmd.op == OPC_BRANCH && i_cmd.operand[15]);

endmodule : crs_regs
